// >>> fail_lamp_model.sv
// Lamp loads with pull-ups on the three open-drain fail pins
`timescale 1ns/1ps
module fail_lamp_model (
    input  wire logic [2:0] oe_n_in,
    input  wire logic [2:0] data_in,
    output logic [2:0]      pin_out
);
    // A released pin is pulled up to the lamp supply
    assign pin_out = oe_n_in | data_in;
endmodule : fail_lamp_model

// >>> fail_output_controller.sv
// Failure logic and pattern drivers for three open-drain fail outputs
`timescale 1ns/1ps
`include "fail_output_defines.svh"

module fail_output_controller #(
    parameter logic [23:0] BLINK_HALF_CYC = 24'(`BLINK_HALF_CYC),
    parameter logic [17:0] PWM_PERIOD_CYC = 18'(`PWM_PERIOD_CYC)
) (
    input  wire logic                           mclk_in,
    input  wire logic                           reset_in,
    input  wire logic                           ce_in,
    input  wire fail_output_pkg::axi_lite_req_s axi_req_in,
    output fail_output_pkg::axi_lite_resp_s     axi_resp_out,
    input  wire logic [1:0]                     hw_config_in,
    input  wire logic                           wd_trigger_fail_in,
    input  wire logic                           wd_trigger_ok_in,
    input  wire logic                           severe_thermal_shutdown_in,
    input  wire logic                           main_short_in,
    input  wire logic                           main_overvoltage_in,
    input  wire logic                           main_uv_event_in,
    input  wire logic                           main_uv_recover_in,
    input  wire logic                           sleep_entry_in,
    input  wire logic                           stop_wd_disable_in,
    input  wire logic                           static_fail_in,
    input  wire logic                           blink_fail_in,
    input  wire logic                           pulsed_fail_in,
    output logic                                static_fail_out,
    output logic                                static_fail_oe_n_out,
    output logic                                blink_fail_out,
    output logic                                blink_fail_oe_n_out,
    output logic                                pulsed_fail_out,
    output logic                                pulsed_fail_oe_n_out,
    output logic                                fail_safe_entry_out
);

    // Pulsed on-times for each duty choice
    localparam logic [17:0] ON_20  = PWM_PERIOD_CYC / 18'd5;
    localparam logic [17:0] ON_10  = PWM_PERIOD_CYC / 18'd10;
    localparam logic [17:0] ON_5   = PWM_PERIOD_CYC / 18'd20;
    localparam logic [17:0] ON_2P5 = PWM_PERIOD_CYC / 18'd40;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic        test_on_r;
    logic [1:0]  duty_r;
    logic        ov_en_r;
    logic        failure_r;
    logic        wd_status_r;
    logic        fo_fault_r;
    logic [1:0]  wd_cnt_r;
    logic [2:0]  uv_cnt_r;
    logic        fs_entry_r;
    logic [23:0] blink_cnt_r;
    logic        blink_phase_r;
    logic [17:0] pwm_cnt_r;
    logic [17:0] on_len;
    logic        active;
    logic [2:0]  pin_s1_r;
    logic [2:0]  pin_s2_r;
    logic [2:0]  pin_s3_r;
    logic [2:0]  pin_lvl_r;
    logic        static_oe_n_r;
    logic        blink_oe_n_r;
    logic        pulsed_oe_n_r;
    logic        aw_held_r;
    logic [31:0] aw_addr_r;
    logic        w_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        wr_do;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        sw_clear;
    logic        wd_first;
    logic        wd_act;
    logic        wd_flag;
    logic        ov_act;
    logic        uv_act;
    logic        nonwd_act;
    logic        fo_set;
    logic        flag_set;
    logic        cond_any;
    logic        cfg_early;
    logic [31:0] rd_mux;

    // ----------------------------------------
    // Failure detection
    // ----------------------------------------
    // Cause decode for the current cycle
    assign cfg_early = (hw_config_in == fail_output_pkg::CFG_ONE) ||
                       (hw_config_in == fail_output_pkg::CFG_TWO);
    assign wd_first  = wd_trigger_fail_in && (wd_cnt_r == 2'h0);
    assign wd_act    = wd_trigger_fail_in && (cfg_early || !wd_first);
    assign wd_flag   = wd_act && !(wd_first &&
                       (hw_config_in == fail_output_pkg::CFG_TWO));
    assign ov_act    = main_overvoltage_in && ov_en_r;
    assign uv_act    = main_uv_event_in && (uv_cnt_r == (`UV_LIMIT - 3'h1));
    assign nonwd_act = severe_thermal_shutdown_in || main_short_in ||
                       ov_act || uv_act;
    assign fo_set    = nonwd_act || wd_act;
    assign flag_set  = nonwd_act || wd_flag;
    assign cond_any  = severe_thermal_shutdown_in || main_short_in ||
                       ov_act || wd_status_r;

    // Watchdog failure counter, restarted by a good trigger
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            wd_cnt_r <= 2'h0;
        end else if (ce_in) begin
            if (wd_trigger_fail_in && wd_cnt_r != `WD_CNT_MAX) begin
                wd_cnt_r <= wd_cnt_r + 2'h1;
            end else if (wd_trigger_ok_in && !wd_trigger_fail_in) begin
                wd_cnt_r <= 2'h0;
            end
        end
    end

    // Consecutive undervoltage counter
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            uv_cnt_r <= 3'h0;
        end else if (ce_in) begin
            if (uv_act || (main_uv_recover_in && !main_uv_event_in)) begin
                uv_cnt_r <= 3'h0;
            end else if (main_uv_event_in) begin
                uv_cnt_r <= uv_cnt_r + 3'h1;
            end
        end
    end

    // Watchdog fail status, a new failure wins over any clear
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            wd_status_r <= 1'b0;
        end else if (ce_in) begin
            if (wd_trigger_fail_in) begin
                wd_status_r <= 1'b1;
            end else if (wd_trigger_ok_in || sleep_entry_in ||
                         stop_wd_disable_in || nonwd_act) begin
                wd_status_r <= 1'b0;
            end
        end
    end

    // Failure flag, a new activation wins over the software clear
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            failure_r <= 1'b0;
        end else if (ce_in) begin
            if (flag_set) begin
                failure_r <= 1'b1;
            end else if (sw_clear) begin
                failure_r <= 1'b0;
            end
        end
    end

    // Latched fail state, held until causes are gone and flag is cleared
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            fo_fault_r <= 1'b0;
        end else if (ce_in) begin
            if (fo_set) begin
                fo_fault_r <= 1'b1;
            end else if (!failure_r && !cond_any) begin
                fo_fault_r <= 1'b0;
            end
        end
    end

    // One pulse when a failure takes the device into fail-safe
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            fs_entry_r <= 1'b0;
        end else if (ce_in) begin
            fs_entry_r <= flag_set && !failure_r;
        end
    end

    // ----------------------------------------
    // Output patterns
    // ----------------------------------------
    // The test bit only adds to the latched fail state
    assign active = fo_fault_r || test_on_r;

    // Duty choice for the pulsed output
    always_comb begin
        unique case (fail_output_pkg::duty_e'(duty_r))
            fail_output_pkg::DUTY_20:  on_len = ON_20;
            fail_output_pkg::DUTY_10:  on_len = ON_10;
            fail_output_pkg::DUTY_5:   on_len = ON_5;
            fail_output_pkg::DUTY_2P5: on_len = ON_2P5;
        endcase
    end

    // Pattern counters, held at zero while idle so all start together
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            blink_cnt_r   <= 24'h0;
            blink_phase_r <= 1'b0;
            pwm_cnt_r     <= 18'h0;
        end else if (ce_in) begin
            if (!active) begin
                blink_cnt_r   <= 24'h0;
                blink_phase_r <= 1'b0;
                pwm_cnt_r     <= 18'h0;
            end else begin
                if (blink_cnt_r == BLINK_HALF_CYC - 24'h1) begin
                    blink_cnt_r   <= 24'h0;
                    blink_phase_r <= ~blink_phase_r;
                end else begin
                    blink_cnt_r <= blink_cnt_r + 24'h1;
                end
                if (pwm_cnt_r == PWM_PERIOD_CYC - 18'h1) begin
                    pwm_cnt_r <= 18'h0;
                end else begin
                    pwm_cnt_r <= pwm_cnt_r + 18'h1;
                end
            end
        end
    end

    // Registered pin enables, low pulls the pin down
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            static_oe_n_r <= 1'b1;
            blink_oe_n_r  <= 1'b1;
            pulsed_oe_n_r <= 1'b1;
        end else if (ce_in) begin
            static_oe_n_r <= !active;
            blink_oe_n_r  <= !(active && !blink_phase_r);
            pulsed_oe_n_r <= !(active && (pwm_cnt_r < on_len));
        end
    end

    // Open-drain pins only ever drive low
    assign static_fail_out      = 1'b0;
    assign blink_fail_out       = 1'b0;
    assign pulsed_fail_out      = 1'b0;
    assign static_fail_oe_n_out = static_oe_n_r;
    assign blink_fail_oe_n_out  = blink_oe_n_r;
    assign pulsed_fail_oe_n_out = pulsed_oe_n_r;
    assign fail_safe_entry_out  = fs_entry_r;

    // Pin readback, a level counts once the last two stages agree
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pin_s1_r  <= 3'h7;
            pin_s2_r  <= 3'h7;
            pin_s3_r  <= 3'h7;
            pin_lvl_r <= 3'h7;
        end else if (ce_in) begin
            pin_s1_r  <= {pulsed_fail_in, blink_fail_in, static_fail_in};
            pin_s2_r  <= pin_s1_r;
            pin_s3_r  <= pin_s2_r;
            pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r ^ pin_s3_r));
        end
    end

    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------
    // Channel acceptance, nothing is taken while frozen
    assign aw_take  = axi_req_in.awvalid && ce_in && !aw_held_r && !bvalid_r;
    assign w_take   = axi_req_in.wvalid && ce_in && !w_held_r && !bvalid_r;
    assign ar_take  = axi_req_in.arvalid && ce_in && !rvalid_r;
    assign wr_do    = ce_in && aw_held_r && w_held_r;
    assign wr_ctrl  = wr_do && (aw_addr_r == `REG_CTRL_OFS) && w_strb_r[0];
    assign wr_stat  = wr_do && (aw_addr_r == `REG_STAT_OFS) && w_strb_r[0];
    assign sw_clear = wr_stat && w_data_r[`STAT_FAIL_BIT];

    // Write address and data are held until both are present
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 32'h0;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
        end else if (ce_in) begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {axi_req_in.awaddr[31:2], 2'b00};
            end else if (wr_do) begin
                aw_held_r <= 1'b0;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= axi_req_in.wdata;
                w_strb_r <= axi_req_in.wstrb;
            end else if (wr_do) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response, error for an unmapped address
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else if (ce_in) begin
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r  <= ((aw_addr_r == `REG_CTRL_OFS) || (aw_addr_r == `REG_STAT_OFS)) ?
                            `RESP_OKAY : `RESP_SLVERR;
            end else if (axi_req_in.bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Control register
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            {ov_en_r, duty_r, test_on_r} <= `CTRL_RESET;
        end else if (ce_in && wr_ctrl) begin
            test_on_r <= w_data_r[`CTRL_TEST_BIT];
            duty_r    <= w_data_r[`CTRL_DUTY_LSB +: 2];
            ov_en_r   <= w_data_r[`CTRL_OV_EN_BIT];
        end
    end

    // Read data selection
    always_comb begin
        rd_mux = 32'h0;
        if ({axi_req_in.araddr[31:2], 2'b00} == `REG_CTRL_OFS) begin
            rd_mux[`CTRL_TEST_BIT]       = test_on_r;
            rd_mux[`CTRL_DUTY_LSB +: 2]  = duty_r;
            rd_mux[`CTRL_OV_EN_BIT]      = ov_en_r;
        end else if ({axi_req_in.araddr[31:2], 2'b00} == `REG_STAT_OFS) begin
            rd_mux[`STAT_FAIL_BIT]       = failure_r;
            rd_mux[`STAT_WD_BIT]         = wd_status_r;
            rd_mux[`STAT_ACT_BIT]        = active;
            rd_mux[`STAT_PIN_LSB +: 3]   = pin_lvl_r;
            rd_mux[`STAT_UV_LSB +: 3]    = uv_cnt_r;
        end
    end

    // Read response, one cycle after the address
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= `RESP_OKAY;
        end else if (ce_in) begin
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_mux;
                rresp_r  <= (({axi_req_in.araddr[31:2], 2'b00} == `REG_CTRL_OFS) ||
                             ({axi_req_in.araddr[31:2], 2'b00} == `REG_STAT_OFS)) ?
                            `RESP_OKAY : `RESP_SLVERR;
            end else if (axi_req_in.rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Bus outputs
    assign axi_resp_out.awready = ce_in && !aw_held_r && !bvalid_r;
    assign axi_resp_out.wready  = ce_in && !w_held_r && !bvalid_r;
    assign axi_resp_out.bvalid  = bvalid_r;
    assign axi_resp_out.bresp   = bresp_r;
    assign axi_resp_out.arready = ce_in && !rvalid_r;
    assign axi_resp_out.rvalid  = rvalid_r;
    assign axi_resp_out.rdata   = rdata_r;
    assign axi_resp_out.rresp   = rresp_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_uv_limit;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && main_uv_event_in && uv_cnt_r == 3'h3) |=> (fo_fault_r && failure_r);
    endproperty
    a_uv_limit: assert property (p_uv_limit)
        else $error("fourth undervoltage did not activate");

    property p_ov_gate;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && main_overvoltage_in && ov_en_r) |=> fo_fault_r;
    endproperty
    a_ov_gate: assert property (p_ov_gate)
        else $error("enabled overvoltage did not activate");

    property p_tsd_failsafe;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && severe_thermal_shutdown_in && !failure_r) |=> (fs_entry_r && fo_fault_r);
    endproperty
    a_tsd_failsafe: assert property (p_tsd_failsafe)
        else $error("thermal shutdown missed fail-safe entry");

    property p_cfg2_first;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && hw_config_in == 2'h1 && wd_trigger_fail_in && wd_cnt_r == 2'h0 &&
         !nonwd_act && !failure_r) |=> (!failure_r && fo_fault_r);
    endproperty
    a_cfg2_first: assert property (p_cfg2_first)
        else $error("first watchdog failure in config two set the flag");

    property p_late_cfg;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && hw_config_in[1] && wd_trigger_fail_in && wd_cnt_r == 2'h0 &&
         !nonwd_act && !fo_fault_r) |=> !fo_fault_r;
    endproperty
    a_late_cfg: assert property (p_late_cfg)
        else $error("first watchdog failure activated in config three or four");

    property p_wd_sleep;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && sleep_entry_in && !wd_trigger_fail_in) |=> !wd_status_r;
    endproperty
    a_wd_sleep: assert property (p_wd_sleep)
        else $error("watchdog fail status kept over sleep entry");

    property p_hold;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && fo_fault_r && (cond_any || failure_r)) |=> fo_fault_r;
    endproperty
    a_hold: assert property (p_hold)
        else $error("fail state released too early");

    property p_off;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && !fo_fault_r && !test_on_r) |=>
        (static_fail_oe_n_out && blink_fail_oe_n_out && pulsed_fail_oe_n_out);
    endproperty
    a_off: assert property (p_off)
        else $error("pin driven without fail state or test bit");

    property p_pulse_edges;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && active && pwm_cnt_r == on_len) |=> pulsed_fail_oe_n_out;
    endproperty
    a_pulse_edges: assert property (p_pulse_edges)
        else $error("pulsed output on past its duty");

    property p_static;
        @(posedge mclk_in) disable iff (reset_in)
        (ce_in && active) |=> !static_fail_oe_n_out;
    endproperty
    a_static: assert property (p_static)
        else $error("static output not low while active");

endmodule : fail_output_controller

// >>> fail_output_defines.svh
// Offsets, field positions, reset values and timing counts of the fail output block
`ifndef FAIL_OUTPUT_DEFINES_SVH
`define FAIL_OUTPUT_DEFINES_SVH

// ----------------------------------------
// Clock and pattern timing
// ----------------------------------------
`define CLK_PERIOD_NS   40
`define BLINK_PERIOD_NS 800000000
`define PWM_PERIOD_NS   10000000
`define BLINK_HALF_CYC  (`BLINK_PERIOD_NS / 2 / `CLK_PERIOD_NS)
`define PWM_PERIOD_CYC  (`PWM_PERIOD_NS / `CLK_PERIOD_NS)

// ----------------------------------------
// Failure counting
// ----------------------------------------
`define UV_LIMIT        3'h4
`define WD_CNT_MAX      2'h2

// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define REG_CTRL_OFS    32'h0000_0000
`define REG_STAT_OFS    32'h0000_0004
`define CTRL_TEST_BIT   0
`define CTRL_DUTY_LSB   1
`define CTRL_OV_EN_BIT  3
`define CTRL_RESET      4'h0
`define STAT_FAIL_BIT   0
`define STAT_WD_BIT     1
`define STAT_ACT_BIT    2
`define STAT_PIN_LSB    4
`define STAT_UV_LSB     8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> fail_output_pkg.sv
// Types shared by the fail output block
package fail_output_pkg;

    // Hardware configuration one to four
    typedef enum logic [1:0] {
        CFG_ONE   = 2'h0,
        CFG_TWO   = 2'h1,
        CFG_THREE = 2'h2,
        CFG_FOUR  = 2'h3
    } hw_config_e;

    // Pulsed output duty selection
    typedef enum logic [1:0] {
        DUTY_20   = 2'h0,
        DUTY_10   = 2'h1,
        DUTY_5    = 2'h2,
        DUTY_2P5  = 2'h3
    } duty_e;

    // Master to slave signals of the register bus
    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axi_lite_req_s;

    // Slave to master signals of the register bus
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_lite_resp_s;

endpackage : fail_output_pkg

// >>> testbench.sv
// Register-level tests of the fail output controller
`timescale 1ns/1ps
module testbench;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    fail_output_pkg::axi_lite_req_s  req = '0;
    fail_output_pkg::axi_lite_resp_s resp;
    logic [1:0]  cfg = 2'h0;
    logic        ce = 1'b1;
    logic [5:0]  pls = 6'h00;
    logic [2:0]  lvl = 3'h0;
    logic [2:0]  oe_n, dat, pin, e;
    logic        fse;
    logic [31:0] rd;
    logic [1:0]  rsp;
    int errors = 0, cmp_count = 0, fs = 0, fs0, lo_b, lo_p;

    fail_output_controller #(.BLINK_HALF_CYC(24'h14), .PWM_PERIOD_CYC(18'h190)) dut (
        .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce),
        .axi_req_in(req), .axi_resp_out(resp), .hw_config_in(cfg),
        .wd_trigger_fail_in(pls[0]), .wd_trigger_ok_in(pls[1]),
        .main_uv_event_in(pls[2]), .main_uv_recover_in(pls[3]),
        .sleep_entry_in(pls[4]), .stop_wd_disable_in(pls[5]),
        .severe_thermal_shutdown_in(lvl[0]), .main_short_in(lvl[1]),
        .main_overvoltage_in(lvl[2]), .static_fail_in(pin[0]),
        .blink_fail_in(pin[1]), .pulsed_fail_in(pin[2]),
        .static_fail_out(dat[0]), .static_fail_oe_n_out(oe_n[0]),
        .blink_fail_out(dat[1]), .blink_fail_oe_n_out(oe_n[1]),
        .pulsed_fail_out(dat[2]), .pulsed_fail_oe_n_out(oe_n[2]),
        .fail_safe_entry_out(fse));
    fail_lamp_model lamps (.oe_n_in(oe_n), .data_in(dat), .pin_out(pin));

    // Clock and fail-safe entry tally
    initial forever #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (fse === 1'b1) fs <= fs + 1;

    task automatic check(input string nm, input logic [31:0] s, x);
        cmp_count++;
        if (s !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask : check

    // Bus write: both channels offered together, released when taken
    task automatic wr(input logic [31:0] a, d);
        logic ta, tw, b;
        logic [1:0] br;
        int n;
        n = 0;
        @(posedge mclk_in);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(negedge mclk_in);
            ta = resp.awready;
            tw = resp.wready;
            b = resp.bvalid;
            br = resp.bresp;
            @(posedge mclk_in);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            n++;
        end while (b !== 1'b1 && n < 50);
        req.bready <= 1'b0;
        if (b !== 1'b1) errors++;
        check("bresp", br, 2'h0);
    endtask : wr

    // Bus read: rdata and rresp taken at the edge where rvalid is seen
    task automatic rdr(input logic [31:0] a);
        logic t, v;
        int n;
        n = 0;
        @(posedge mclk_in);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(negedge mclk_in);
            t = resp.arready;
            v = resp.rvalid;
            rd = resp.rdata;
            rsp = resp.rresp;
            @(posedge mclk_in);
            if (t) req.arvalid <= 1'b0;
            n++;
        end while (v !== 1'b1 && n < 50);
        req.rready <= 1'b0;
        if (v !== 1'b1) errors++;
    endtask : rdr

    task automatic pulse(input int b);
        @(posedge mclk_in) pls[b] <= 1'b1;
        @(posedge mclk_in) pls[b] <= 1'b0;
    endtask : pulse

    // Settle, then compare static pin enable and status flags
    task automatic stat(input logic [2:0] f, input logic o);
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        check("static pin", oe_n[0], o);
        rdr(32'h4);
        check("status", rd[2:0], f);
    endtask : stat

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        repeat (5000) @(posedge mclk_in);
        errors++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        rdr(32'h0);
        check("ctrl", rd, 32'h0);
        rdr(32'h4);
        check("status", rd & 32'h777, 32'h70);
        rdr(32'h8);
        check("unmapped", rsp, 2'h2);
        wr(32'h0, 32'h1);
        stat(3'h4, 1'b0);
        check("all pins", oe_n, 3'h0);
        wr(32'h0, 32'h0);
        stat(3'h0, 1'b1);
        $display("test bit done");
        for (int k = 0; k < 4; k++) begin
            if (k == 3) wr(32'h0, 32'h8);
            e = (k == 2) ? 3'h0 : 3'h5;
            fs0 = fs;
            lvl[(k == 3) ? 2 : k] <= 1'b1;
            stat(e, k == 2);
            check("fail safe", fs - fs0, k != 2);
            wr(32'h4, 32'h1);
            stat(e, k == 2);
            lvl <= 3'h0;
            wr(32'h4, 32'h1);
            stat(3'h0, 1'b1);
        end
        $display("level causes done");
        repeat (3) pulse(2);
        pulse(3);
        repeat (3) pulse(2);
        stat(3'h0, 1'b1);
        check("uv count", rd[10:8], 3'h3);
        pulse(2);
        stat(3'h5, 1'b0);
        wr(32'h4, 32'h1);
        stat(3'h0, 1'b1);
        $display("undervoltage done");
        for (int c = 0; c < 4; c++) begin
            cfg <= c[1:0];
            fs0 = fs;
            pulse(0);
            stat({c < 2, 1'b1, c == 0}, c > 1);
            check("fail safe", fs - fs0, c == 0);
            pulse(0);
            wr(32'h4, 32'h1);
            stat(3'h6, 1'b0);
            pulse(1);
            wr(32'h4, 32'h1);
            stat(3'h0, 1'b1);
        end
        cfg <= 2'h0;
        for (int b = 4; b < 6; b++) begin
            pulse(0);
            pulse(b);
            wr(32'h4, 32'h1);
            stat(3'h0, 1'b1);
        end
        // Frozen block ignores a watchdog failure
        ce <= 1'b0;
        pulse(0);
        ce <= 1'b1;
        stat(3'h0, 1'b1);
        $display("watchdog done");
        for (int d = 0; d < 4; d++) begin
            wr(32'h0, 32'(1 + 2 * d));
            lo_b = 0;
            lo_p = 0;
            repeat (400) begin
                @(negedge mclk_in);
                lo_b += !oe_n[1];
                lo_p += !oe_n[2];
            end
            check("static pin", oe_n[0], 1'b0);
            check("blink low", lo_b, 200);
            check("pulse low", lo_p, 80 >> d);
            rdr(32'h4);
            check("static level", rd[4], 1'b0);
            wr(32'h0, 32'h0);
        end
        $display("patterns done");
        end_sim();
    end
endmodule : testbench
